// [hdl/dxc_ext_regs.sv]
// Purpose: Extended display control registers behind the indexed data port
// Assumes: Host strobes are one-cycle pulses on clk; pins and detectors are asynchronous
// Notes:   Pixel pins are registered, so they lag the internal sources by one cycle
`timescale 1ns/1ps
`include "dxc_map.svh"

// How it works
// - Bits 7:2 of access control give frame buffer access length in memory clocks.
// - Bit 1 enables frame buffer reads, bit 0 enables writes.
// - Lock bit 6 set blocks writes to vertical display end and overflow bits 6,1.
// - Lock bit 4 set blocks writes to horizontal display end register.
// - Lock bits 1:0 pick text vertical expansion, only in 400-line text modes.
// - Feature bit 7 turns pixel clock, blank and video pins into inputs.
// - Feature bit 5 makes line pulse copy hsync and frame pulse copy vsync.
// - Feature bit 4 holds pixel clock low; blank and video low in CRT-only mode.
// - Feature bit 3 forces both sync outputs low.
// - Feature bits 6 and 2 go out as the TFT dithering mode select.
// - Clock selection accepts writes only while unlock bits 6:4 hold 101.
// - Clock selection bits 4:3 and misc output bits 3:2 choose the dot clock.
// - Clock selection bits 2:0 drive the memory clock choice.
// - Dot clock N value applies only when dot clock choice equals 0010.
// - Override bit 5 replaces the five detector latches with bits 4:0.
// - Refresh divides reference by 8*(value+1), each request lasting 8 periods.
// - Divider runs only with dither bit 1; bit 0 clear passes reference through.
// - Status bit 7 enables the user status pin; bits 6:5 pick I/O, memory, both.
// - Status bit 4 clear makes the user status pin active high, set low.
// - Status bits 2:0 read DAC, panel and pixel bus voltage modes.
module dxc_ext_regs
  import dxc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Host I/O port
  input  wire dxc_io_req_t io_req,
  output logic [7:0]       io_rdata,
  output logic             io_rhit,
  // CRT register write guard
  input  wire logic [7:0]  crt_index,
  output logic [7:0]       crt_wr_mask,
  // Frame buffer arbitration
  output logic [5:0]       fb_access_mclks,
  output logic             fb_read_en,
  output logic             fb_write_en,
  // Text expansion
  input  wire logic        text400_mode,
  output dxc_vexp_t        vexp_mode,
  // Display pins
  input  wire dxc_pins_t   pins_int,
  input  wire logic        crt_only,
  input  wire logic        pclk_pin_in,
  input  wire logic        blank_pin_in,
  input  wire logic [7:0]  video_data_pins_in,
  output dxc_pins_t        pins_out,
  output logic             pix_pins_oe,
  output logic             aux_video_extender_mode,
  output logic             dac_pclk,
  output logic             dac_blank,
  output logic [7:0]       dac_video,
  output logic [1:0]       tft_dither_sel,
  // Clock generator
  input  wire logic [1:0]  misc_clk_sel,
  output logic [3:0]       dot_clock_choice,
  output logic [2:0]       memory_clock_choice,
  output logic [7:0]       dot_n_value,
  output logic             dot_n_active,
  // Voltage detectors, bit 4 pixel bus down to bit 0 DAC
  input  wire logic [4:0]  volt_detect,
  output logic [4:0]       volt_mode,
  // Refresh
  input  wire logic        slow_reference_clock,
  input  wire logic        refresh_div_en,
  output logic             refresh_req,
  // User status pin
  input  wire logic        io_activity,
  input  wire logic        mem_activity,
  output logic             user_status_pin
);

  // ------
  // Register state
  // ------
  logic [7:0] index;
  logic [7:0] frame_buffer_access_ctrl;
  logic [7:0] crt_lock_two;
  logic [7:0] feature_three;
  logic [7:0] clock_selection;
  logic [7:0] dot_clock_n_value;
  logic [7:0] voltage_override;
  logic [7:0] refresh_timing;
  logic [7:0] clock_unlock;
  logic [7:0] status_detect;
  logic [7:0] next_index;
  logic [7:0] next_frame_buffer_access_ctrl;
  logic [7:0] next_crt_lock_two;
  logic [7:0] next_feature_three;
  logic [7:0] next_clock_selection;
  logic [7:0] next_dot_clock_n_value;
  logic [7:0] next_voltage_override;
  logic [7:0] next_refresh_timing;
  logic [7:0] next_clock_unlock;
  logic [7:0] next_status_detect;
  logic       data_wr;
  logic       data_rd;
  logic       clk_unlocked;
  logic [7:0] rd_value;
  logic       rd_hit;

  assign data_wr      = io_req.wr && (io_req.addr == `DXC_PORT_DATA);
  assign data_rd      = io_req.rd && (io_req.addr == `DXC_PORT_DATA);
  assign clk_unlocked = (clock_unlock[6:4] == `DXC_UNLOCK_KEY);

  always_comb begin
    next_index                    = index;
    next_frame_buffer_access_ctrl = frame_buffer_access_ctrl;
    next_crt_lock_two             = crt_lock_two;
    next_feature_three            = feature_three;
    next_clock_selection          = clock_selection;
    next_dot_clock_n_value        = dot_clock_n_value;
    next_voltage_override         = voltage_override;
    next_refresh_timing           = refresh_timing;
    next_clock_unlock             = clock_unlock;
    next_status_detect            = status_detect;
    if (io_req.wr && (io_req.addr == `DXC_PORT_INDEX)) begin
      next_index = io_req.wdata;
    end
    if (data_wr) begin
      case (index)
        `DXC_IDX_FBAC:    next_frame_buffer_access_ctrl = io_req.wdata;
        `DXC_IDX_CRTLOCK: next_crt_lock_two = io_req.wdata & `DXC_MASK_CRTLOCK;
        `DXC_IDX_FEATURE: next_feature_three = io_req.wdata & `DXC_MASK_FEATURE;
        `DXC_IDX_CLKSEL: begin
          // Locked writes vanish without a trace; the stored value stays readable
          if (clk_unlocked) begin
            next_clock_selection = io_req.wdata & `DXC_MASK_CLKSEL;
          end
        end
        `DXC_IDX_DOTN:    next_dot_clock_n_value = io_req.wdata;
        `DXC_IDX_VOLT:    next_voltage_override = io_req.wdata & `DXC_MASK_VOLT;
        `DXC_IDX_REFRESH: next_refresh_timing = io_req.wdata;
        `DXC_IDX_UNLOCK:  next_clock_unlock = io_req.wdata & `DXC_MASK_UNLOCK;
        `DXC_IDX_STATUS:  next_status_detect = io_req.wdata & `DXC_MASK_STATUS;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      index                    <= `DXC_RESET_VALUE;
      frame_buffer_access_ctrl <= `DXC_RESET_VALUE;
      crt_lock_two             <= `DXC_RESET_VALUE;
      feature_three            <= `DXC_RESET_VALUE;
      clock_selection          <= `DXC_RESET_VALUE;
      dot_clock_n_value        <= `DXC_RESET_VALUE;
      voltage_override         <= `DXC_RESET_VALUE;
      refresh_timing           <= `DXC_RESET_VALUE;
      clock_unlock             <= `DXC_RESET_VALUE;
      status_detect            <= `DXC_RESET_VALUE;
    end else begin
      index                    <= next_index;
      frame_buffer_access_ctrl <= next_frame_buffer_access_ctrl;
      crt_lock_two             <= next_crt_lock_two;
      feature_three            <= next_feature_three;
      clock_selection          <= next_clock_selection;
      dot_clock_n_value        <= next_dot_clock_n_value;
      voltage_override         <= next_voltage_override;
      refresh_timing           <= next_refresh_timing;
      clock_unlock             <= next_clock_unlock;
      status_detect            <= next_status_detect;
    end
  end

  // ------
  // Read path
  // ------
  always_comb begin
    rd_hit   = 1'b1;
    rd_value = 8'h00;
    case (index)
      `DXC_IDX_FBAC:    rd_value = frame_buffer_access_ctrl;
      `DXC_IDX_CRTLOCK: rd_value = crt_lock_two;
      `DXC_IDX_FUTURE:  rd_value = 8'h00;
      `DXC_IDX_FEATURE: rd_value = feature_three;
      `DXC_IDX_CLKSEL:  rd_value = clock_selection;
      `DXC_IDX_DOTN:    rd_value = dot_clock_n_value;
      `DXC_IDX_VOLT:    rd_value = voltage_override;
      `DXC_IDX_REFRESH: rd_value = refresh_timing;
      `DXC_IDX_UNLOCK:  rd_value = clock_unlock;
      `DXC_IDX_STATUS:  rd_value = {status_detect[7:3],
                                    volt_mode[0], volt_mode[2], volt_mode[4]};
      default:          rd_hit = 1'b0;
    endcase
  end

  // Data comes back registered one cycle after the read strobe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      io_rdata <= 8'h00;
      io_rhit  <= 1'b0;
    end else begin
      io_rdata <= data_rd ? rd_value : 8'h00;
      io_rhit  <= data_rd & rd_hit;
    end
  end

  // ------
  // CRT write guard
  // ------
  always_comb begin
    crt_wr_mask = 8'hff;
    case (crt_index)
      `DXC_CRT_VDE: begin
        if (crt_lock_two[`DXC_LOCK_VDE]) crt_wr_mask = 8'h00;
      end
      `DXC_CRT_OVERFLOW: begin
        if (crt_lock_two[`DXC_LOCK_VDE]) crt_wr_mask = ~`DXC_OVF_LOCK_MASK;
      end
      `DXC_CRT_HDE: begin
        if (crt_lock_two[`DXC_LOCK_HDE]) crt_wr_mask = 8'h00;
      end
      default: crt_wr_mask = 8'hff;
    endcase
  end

  // ------
  // Control decodes
  // ------
  assign fb_access_mclks     = frame_buffer_access_ctrl[7:2];
  assign fb_read_en          = frame_buffer_access_ctrl[`DXC_FBAC_RD];
  assign fb_write_en         = frame_buffer_access_ctrl[`DXC_FBAC_WR];
  assign tft_dither_sel      = {feature_three[`DXC_FEAT_DITH_HI],
                                feature_three[`DXC_FEAT_DITH_LO]};
  assign dot_clock_choice    = {clock_selection[4:3], misc_clk_sel};
  assign memory_clock_choice = clock_selection[2:0];
  assign dot_n_value         = dot_clock_n_value;
  assign dot_n_active        = (dot_clock_choice == `DXC_DOT_N_CODE);

  always_comb begin
    vexp_mode = DXC_VEXP_NONE;
    if (text400_mode && crt_lock_two[0]) begin
      vexp_mode = crt_lock_two[1] ? DXC_VEXP_ONE_ABOVE_TWO_BELOW : DXC_VEXP_THREE_BELOW;
    end
  end

  // ------
  // Asynchronous inputs: two-stage synchronisers
  // ------
  logic [4:0] volt_s1;
  logic [4:0] volt_s2;
  logic [9:0] pix_s1;
  logic [9:0] pix_s2;
  logic [2:0] ref_s;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      volt_s1 <= '0;
      volt_s2 <= '0;
      pix_s1  <= '0;
      pix_s2  <= '0;
      ref_s   <= '0;
    end else begin
      volt_s1 <= volt_detect;
      volt_s2 <= volt_s1;
      pix_s1  <= {pclk_pin_in, blank_pin_in, video_data_pins_in};
      pix_s2  <= pix_s1;
      ref_s   <= {ref_s[1:0], slow_reference_clock};
    end
  end

  // Override replaces each detector latch: 1 forces 3.3 V, 0 forces 5 V
  assign volt_mode = voltage_override[`DXC_VOLT_OVR] ? voltage_override[4:0] : volt_s2;

  // ------
  // Refresh divider
  // ------
  dxc_refresh_div #(
    .DIV_W (`DXC_REF_DIV_W)
  ) u_refresh (
    .clk         (clk),
    .rst_n       (rst_n),
    .enable      (refresh_div_en),
    .ref_level   (ref_s[1]),
    .ref_edge    (ref_s[1] & ~ref_s[2]),
    .div_value   (refresh_timing),
    .refresh_req (refresh_req)
  );

  // ------
  // Display pin control
  // ------
  dxc_pins_t next_pins;
  logic      next_status;
  logic      hit;

  assign aux_video_extender_mode = feature_three[`DXC_FEAT_AVE];
  assign pix_pins_oe             = ~feature_three[`DXC_FEAT_AVE];
  // In extender mode the palette takes the external source, otherwise the internal one
  assign dac_pclk  = feature_three[`DXC_FEAT_AVE] ? pix_s2[9]   : pins_int.pclk;
  assign dac_blank = feature_three[`DXC_FEAT_AVE] ? pix_s2[8]   : pins_int.blank;
  assign dac_video = feature_three[`DXC_FEAT_AVE] ? pix_s2[7:0] : pins_int.vid;

  always_comb begin
    next_pins = pins_int;
    if (feature_three[`DXC_FEAT_SYNCPASS]) begin
      next_pins.line_pulse  = pins_int.hsync;
      next_pins.frame_pulse = pins_int.vsync;
    end
    if (feature_three[`DXC_FEAT_PIXOFF]) begin
      next_pins.pclk = 1'b0;
      if (crt_only) begin
        next_pins.blank = 1'b0;
        next_pins.vid   = 8'h00;
      end
    end
    if (feature_three[`DXC_FEAT_SYNCOFF]) begin
      next_pins.hsync = 1'b0;
      next_pins.vsync = 1'b0;
    end
  end

  // ------
  // User status pin
  // ------
  always_comb begin
    case (dxc_stat_sel_t'(status_detect[6:5]))
      DXC_STAT_IO:   hit = io_activity;
      DXC_STAT_MEM:  hit = mem_activity;
      DXC_STAT_BOTH: hit = io_activity | mem_activity;
      default:       hit = 1'b0;
    endcase
    // Disabled or reserved selection leaves the pin at its inactive level
    next_status = (status_detect[`DXC_STAT_EN] & hit) ^ status_detect[`DXC_STAT_POL];
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pins_out        <= '0;
      user_status_pin <= 1'b0;
    end else begin
      pins_out        <= next_pins;
      user_status_pin <= next_status;
    end
  end

endmodule : dxc_ext_regs

// [hdl/dxc_refresh_div.sv]
// Purpose: Refresh request generator from the slow reference clock
// Assumes: ref_edge is a one-cycle pulse per rising reference edge, already synchronised
// Notes:   Request stays high for a fixed count of reference periods
`timescale 1ns/1ps
`include "dxc_map.svh"

module dxc_refresh_div #(
  parameter int DIV_W = `DXC_REF_DIV_W
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       enable,
  input  wire logic       ref_level,
  input  wire logic       ref_edge,
  input  wire logic [7:0] div_value,
  output logic            refresh_req
);

  logic [DIV_W-1:0] cnt;
  logic [DIV_W-1:0] next_cnt;
  logic [3:0]       width;
  logic [3:0]       next_width;
  logic             divided;
  logic             next_divided;
  logic [DIV_W-1:0] terminal;

  // Divisor is 8*(value+1): upper bits hold value, low three bits count eights
  assign terminal = {div_value, 3'b111};

  // ------
  // Divider and pulse width
  // ------
  always_comb begin
    next_cnt     = cnt;
    next_width   = width;
    next_divided = divided;
    if (!enable) begin
      next_cnt     = '0;
      next_width   = '0;
      next_divided = 1'b0;
    end else if (ref_edge) begin
      if (cnt == terminal) begin
        next_cnt     = '0;
        next_divided = 1'b1;
        next_width   = 4'(`DXC_REF_WIDTH - 1);
      end else begin
        next_cnt = cnt + 1'b1;
        if (width != 4'h0) begin
          next_width = width - 1'b1;
        end else begin
          next_divided = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt     <= '0;
      width   <= '0;
      divided <= 1'b0;
    end else begin
      cnt     <= next_cnt;
      width   <= next_width;
      divided <= next_divided;
    end
  end

  // Bit 0 clear passes the reference straight through
  assign refresh_req = enable & (div_value[0] ? divided : ref_level);

endmodule : dxc_refresh_div

// [shared/dxc_map.svh]
// Purpose: Offsets, field positions, reset values and timing counts of the extended bank
// Assumes: Host reaches the bank through the indexed sequencer pair
// Notes:   Definitions only
`ifndef DXC_MAP_SVH
`define DXC_MAP_SVH

// ------
// Host ports and indices
// ------
`define DXC_PORT_INDEX    16'h03c4
`define DXC_PORT_DATA     16'h03c5
`define DXC_IDX_FBAC      8'h25
`define DXC_IDX_CRTLOCK   8'h27
`define DXC_IDX_FUTURE    8'h28
`define DXC_IDX_FEATURE   8'h29
`define DXC_IDX_CLKSEL    8'h31
`define DXC_IDX_DOTN      8'h32
`define DXC_IDX_VOLT      8'h33
`define DXC_IDX_REFRESH   8'h34
`define DXC_IDX_UNLOCK    8'h35
`define DXC_IDX_STATUS    8'h36

// ------
// Writable masks (reserved bits read as zero) and reset values
// ------
`define DXC_MASK_CRTLOCK  8'h53
`define DXC_MASK_FEATURE  8'hfc
`define DXC_MASK_CLKSEL   8'h1f
`define DXC_MASK_VOLT     8'h3f
`define DXC_MASK_UNLOCK   8'h70
`define DXC_MASK_STATUS   8'hf0
`define DXC_RESET_VALUE   8'h00

// ------
// Field positions
// ------
`define DXC_FBAC_RD       1
`define DXC_FBAC_WR       0
`define DXC_LOCK_VDE      6
`define DXC_LOCK_HDE      4
`define DXC_FEAT_AVE      7
`define DXC_FEAT_DITH_HI  6
`define DXC_FEAT_SYNCPASS 5
`define DXC_FEAT_PIXOFF   4
`define DXC_FEAT_SYNCOFF  3
`define DXC_FEAT_DITH_LO  2
`define DXC_VOLT_OVR      5
`define DXC_STAT_EN       7
`define DXC_STAT_POL      4
`define DXC_UNLOCK_KEY    3'b101
`define DXC_DOT_N_CODE    4'b0010

// ------
// CRT registers guarded by the lock bits
// ------
`define DXC_CRT_HDE       8'h01
`define DXC_CRT_OVERFLOW  8'h07
`define DXC_CRT_VDE       8'h12
`define DXC_OVF_LOCK_MASK 8'h42

// ------
// Refresh timing
// ------
`define DXC_REF_WIDTH     8
`define DXC_REF_DIV_W     11

`endif

// [shared/dxc_pkg.sv]
// Purpose: Types shared by the extended control bank
// Assumes: Offsets and fields live in dxc_map.svh
// Notes:   Pin groups travel as packed structs
package dxc_pkg;

  // ------
  // Display pin group
  // ------
  typedef struct packed {
    logic       pclk;
    logic       blank;
    logic [7:0] vid;
    logic       hsync;
    logic       vsync;
    logic       line_pulse;
    logic       frame_pulse;
  } dxc_pins_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [15:0] addr;
    logic [7:0] wdata;
  } dxc_io_req_t;

  typedef enum logic [1:0] {
    DXC_VEXP_NONE,
    DXC_VEXP_THREE_BELOW,
    DXC_VEXP_ONE_ABOVE_TWO_BELOW
  } dxc_vexp_t;

  typedef enum logic [1:0] {
    DXC_STAT_RSVD,
    DXC_STAT_IO,
    DXC_STAT_MEM,
    DXC_STAT_BOTH
  } dxc_stat_sel_t;

endpackage : dxc_pkg

// [tb/dxc_ext_regs_monitor.sv]
// Purpose: Port checks for the extended control bank
// Assumes: Index, feature, lock and unlock are mirrored from host writes
// Notes:   Mirrors follow the index and data ports only
`timescale 1ns/1ps
`include "dxc_map.svh"
module dxc_ext_regs_monitor
  import dxc_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire dxc_io_req_t io_req,
  input wire logic [7:0]  crt_index,
  input wire logic [7:0]  crt_wr_mask,
  input wire dxc_pins_t   pins_int,
  input wire logic        crt_only,
  input wire dxc_pins_t   pins_out,
  input wire logic        pix_pins_oe,
  input wire logic        aux_video_extender_mode,
  input wire logic [1:0]  misc_clk_sel,
  input wire logic [3:0]  dot_clock_choice,
  input wire logic [2:0]  memory_clock_choice,
  input wire logic        dot_n_active
);
  // ------
  // Mirrors and checks
  // ------
  logic [7:0] idx, feat, lk, unl;
  logic       dw, cw;
  assign dw = io_req.wr && io_req.addr == `DXC_PORT_DATA;
  assign cw = dw && idx == `DXC_IDX_CLKSEL;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {idx, feat, lk, unl} <= '0;
    end else if (io_req.wr && io_req.addr == `DXC_PORT_INDEX) begin
      idx <= io_req.wdata;
    end else if (dw) begin
      if (idx == `DXC_IDX_FEATURE) feat <= io_req.wdata;
      if (idx == `DXC_IDX_CRTLOCK) lk <= io_req.wdata;
      if (idx == `DXC_IDX_UNLOCK) unl <= io_req.wdata;
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  a_dot_n_code: assert property (dot_n_active == (dot_clock_choice == `DXC_DOT_N_CODE))
    else $error("dot_n_active wrong");
  a_dot_misc_bits: assert property (dot_clock_choice[1:0] == misc_clk_sel)
    else $error("dot clock low bits wrong");
  a_pix_oe_follow: assert property (pix_pins_oe == !aux_video_extender_mode)
    else $error("pixel pin enable wrong");
  a_sync_forced_low: assert property ($past(feat[3]) |-> !pins_out.hsync && !pins_out.vsync)
    else $error("sync not forced low");
  a_pulse_copy: assert property ($past(feat[5] && !feat[3]) |->
    pins_out.line_pulse == $past(pins_int.hsync) && pins_out.frame_pulse == $past(pins_int.vsync))
    else $error("line or frame pulse not copied");
  a_pixel_off: assert property ($past(feat[4]) |->
    !pins_out.pclk && ($past(!crt_only) || (!pins_out.blank && pins_out.vid == 8'h00)))
    else $error("pixel pins not held low");
  a_vde_locked: assert property (lk[6] |->
    (crt_index != `DXC_CRT_VDE || crt_wr_mask == 8'h00) &&
    (crt_index != `DXC_CRT_OVERFLOW || crt_wr_mask == 8'hbd))
    else $error("vertical end guard wrong");
  a_hde_locked: assert property (lk[4] && crt_index == `DXC_CRT_HDE |-> crt_wr_mask == 8'h00)
    else $error("horizontal end guard wrong");
  a_clk_refused: assert property (cw && unl[6:4] != `DXC_UNLOCK_KEY |=>
    $stable(memory_clock_choice))
    else $error("locked clock write took effect");
  a_clk_taken: assert property (cw && unl[6:4] == `DXC_UNLOCK_KEY |=>
    memory_clock_choice == $past(io_req.wdata[2:0]))
    else $error("unlocked clock write lost");
  cover property (cw && unl[6:4] != `DXC_UNLOCK_KEY);
  cover property (feat[4] && crt_only);
  cover property (lk[6] && crt_index == `DXC_CRT_VDE);
endmodule : dxc_ext_regs_monitor
bind dxc_ext_regs dxc_ext_regs_monitor mon (.clk, .rst_n, .io_req, .crt_index, .crt_wr_mask,
  .pins_int, .crt_only, .pins_out, .pix_pins_oe, .aux_video_extender_mode, .misc_clk_sel,
  .dot_clock_choice, .memory_clock_choice, .dot_n_active);

// [tb/dxc_host_model.sv]
// Purpose: Host side of the indexed port pair
// Assumes: One-cycle strobes launched just after the rising edge
// Notes:   Released bus carries inverted values, never the last ones
`timescale 1ns/1ps
`include "dxc_map.svh"
module dxc_host_model
  import dxc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic [7:0] io_rdata,
  input  wire logic       io_rhit,
  output dxc_io_req_t     io_req
);
  // ------
  // Bus cycles
  // ------
  initial io_req = '0;
  task automatic cyc(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    #1 io_req = '{w, !w, a, d};
    @(posedge clk);
    #1 io_req = '{1'b0, 1'b0, ~a, ~d};
  endtask : cyc
  task automatic wr(input logic [7:0] i, input logic [7:0] v);
    logic [7:0] d;
    d = v;
    if (i == `DXC_IDX_FEATURE) d[1:0] = 2'b00;
    if (i == `DXC_IDX_DOTN && (d < 8'h38 || d > 8'hbe)) d = 8'h38;
    cyc(1'b1, `DXC_PORT_INDEX, i);
    cyc(1'b1, `DXC_PORT_DATA, d);
  endtask : wr
  // Read data stands one cycle, so it is taken right after the answer edge
  task automatic rd(input logic [7:0] i, output logic [7:0] v, output logic h);
    cyc(1'b1, `DXC_PORT_INDEX, i);
    cyc(1'b0, `DXC_PORT_DATA, 8'h00);
    v = io_rdata;
    h = io_rhit;
  endtask : rd
endmodule : dxc_host_model

// [tb/tb_top.sv]
// Purpose: Self-checking bench for the extended control bank
// Assumes: Host model drives the port pair
// Notes:   Pixel pin inputs other than video data are tied
`timescale 1ns/1ps
`include "dxc_map.svh"
module tb_top;
  import dxc_pkg::*;
  logic clk, rst_n, text400_mode, crt_only, slow_reference_clock, refresh_div_en, hit;
  logic io_activity, mem_activity, io_rhit, fb_read_en, fb_write_en, pix_pins_oe, dac_pclk;
  logic aux_video_extender_mode, dac_blank, dot_n_active, refresh_req, user_status_pin;
  logic [7:0] crt_index, video_data_pins_in, v, io_rdata, crt_wr_mask, dac_video, dot_n_value;
  logic [5:0] fb_access_mclks;
  logic [4:0] volt_detect, volt_mode;
  logic [3:0] dot_clock_choice;
  logic [2:0] memory_clock_choice;
  logic [1:0] misc_clk_sel, tft_dither_sel;
  dxc_vexp_t   vexp_mode;
  dxc_pins_t   pins_int, pins_out;
  dxc_io_req_t io_req;
  int fail_count, num_checks, cycles, rises;
  logic [15:0] st [7] = '{16'h8000, 16'ha001, 16'hc000, 16'he001, 16'hb000, 16'h1001, 16'h0000};
  dxc_ext_regs uut (.clk, .rst_n, .io_req, .io_rdata, .io_rhit, .crt_index, .crt_wr_mask,
    .fb_access_mclks, .fb_read_en, .fb_write_en, .text400_mode, .vexp_mode, .pins_int, .crt_only,
    .pclk_pin_in(1'b0), .blank_pin_in(1'b1), .video_data_pins_in, .pins_out, .pix_pins_oe,
    .aux_video_extender_mode, .dac_pclk, .dac_blank, .dac_video, .tft_dither_sel, .misc_clk_sel,
    .dot_clock_choice, .memory_clock_choice, .dot_n_value, .dot_n_active, .volt_detect,
    .volt_mode, .slow_reference_clock, .refresh_div_en, .refresh_req, .io_activity,
    .mem_activity, .user_status_pin);
  dxc_host_model h (.clk, .io_rdata, .io_rhit, .io_req);
  // ------
  // Checks and scenarios
  // ------
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic rk(input logic [7:0] i, input logic [7:0] e);
    h.rd(i, v, hit);
    chk("rdata", 16'(e), 16'(v));
    chk("rhit", 16'h1, 16'(hit));
  endtask : rk
  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude
  task automatic t_basic;
    foreach (st[k]) rk(8'(k < 3 ? 'h27 + k : 'h2e + k), 8'h00);
    h.rd(8'h40, v, hit);
    chk("unmapped", 16'h0, {v, 7'h0, hit});
    h.wr(`DXC_IDX_FBAC, 8'hfd);
    chk("fbac", 16'hfd, 16'({fb_access_mclks, fb_read_en, fb_write_en}));
    h.wr(`DXC_IDX_FBAC, 8'h06);
    chk("fbac", 16'h06, 16'({fb_access_mclks, fb_read_en, fb_write_en}));
  endtask : t_basic
  task automatic t_lock;
    h.wr(`DXC_IDX_CRTLOCK, 8'hff);
    rk(`DXC_IDX_CRTLOCK, 8'h53);
    crt_index = `DXC_CRT_VDE;
    #1 chk("mask", 16'h00, 16'(crt_wr_mask));
    @(posedge clk) #1 crt_index = `DXC_CRT_HDE;
    #1 chk("mask", 16'h00, 16'(crt_wr_mask));
    @(posedge clk) #1 crt_index = `DXC_CRT_OVERFLOW;
    text400_mode = 1'b1;
    #1 chk("mask", 16'hbd, 16'(crt_wr_mask));
    chk("vexp", 16'(DXC_VEXP_ONE_ABOVE_TWO_BELOW), 16'(vexp_mode));
    h.wr(`DXC_IDX_CRTLOCK, 8'h01);
    chk("vexp", 16'(DXC_VEXP_THREE_BELOW), 16'(vexp_mode));
    text400_mode = 1'b0;
    crt_index = `DXC_CRT_VDE;
    #1 chk("vexp", 16'(DXC_VEXP_NONE), 16'(vexp_mode));
    chk("mask", 16'hff, 16'(crt_wr_mask));
  endtask : t_lock
  task automatic t_feat;
    h.wr(`DXC_IDX_FEATURE, 8'hff);
    rk(`DXC_IDX_FEATURE, 8'hfc);
    chk("dither", 16'h3, 16'(tft_dither_sel));
    chk("dac", 16'h15a, 16'({dac_pclk, dac_blank, dac_video}));
    h.wr(`DXC_IDX_FEATURE, 8'h18);
    chk("dac", 16'h3ff, 16'({dac_pclk, dac_blank, dac_video}));
    @(posedge clk) #1 chk("pins", 16'h0003, 16'(pins_out));
    crt_only = 1'b0;
    @(posedge clk) #1 chk("pins", 16'h1ff3, 16'(pins_out));
    pins_int = 14'h3ff9;
    h.wr(`DXC_IDX_FEATURE, 8'h20);
    @(posedge clk) #1 chk("pins", 16'h3ffa, 16'(pins_out));
  endtask : t_feat
  task automatic t_clock;
    h.wr(`DXC_IDX_CLKSEL, 8'h05);
    rk(`DXC_IDX_CLKSEL, 8'h00);
    h.wr(`DXC_IDX_UNLOCK, 8'h50);
    h.wr(`DXC_IDX_CLKSEL, 8'h1d);
    chk("clk", 16'hf5, 16'({dot_clock_choice, 1'b0, memory_clock_choice}));
    h.wr(`DXC_IDX_UNLOCK, 8'h00);
    h.wr(`DXC_IDX_CLKSEL, 8'h02);
    rk(`DXC_IDX_CLKSEL, 8'h1d);
    h.wr(`DXC_IDX_UNLOCK, 8'h50);
    h.wr(`DXC_IDX_CLKSEL, 8'h00);
    misc_clk_sel = 2'b10;
    h.wr(`DXC_IDX_DOTN, 8'hbe);
    chk("dotn", 16'h1be, 16'({dot_n_active, dot_n_value}));
  endtask : t_clock
  task automatic t_volt;
    chk("volt", 16'h15, 16'(volt_mode));
    rk(`DXC_IDX_STATUS, 8'h07);
    h.wr(`DXC_IDX_VOLT, 8'h21);
    chk("volt", 16'h01, 16'(volt_mode));
    rk(`DXC_IDX_STATUS, 8'h04);
  endtask : t_volt
  task automatic t_status;
    foreach (st[k]) begin
      h.wr(`DXC_IDX_STATUS, st[k][15:8]);
      @(posedge clk) #1 chk("status", 16'(st[k][0]), 16'(user_status_pin));
    end
  endtask : t_status
  task automatic t_refresh;
    refresh_div_en = 1'b1;
    slow_reference_clock = 1'b1;
    repeat (4) @(posedge clk);
    #1 chk("pass", 16'h1, 16'(refresh_req));
    refresh_div_en = 1'b0;
    h.wr(`DXC_IDX_REFRESH, 8'h01);
    refresh_div_en = 1'b1;
    rises = 0;
    repeat (144) begin
      repeat (4) @(posedge clk);
      #1 slow_reference_clock = ~slow_reference_clock;
    end
    chk("rises", 16'h4, 16'(rises));
    refresh_div_en = 1'b0;
    @(posedge clk) #1 chk("off", 16'h0, 16'(refresh_req));
  endtask : t_refresh
  always @(posedge refresh_req) rises++;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      conclude;
    end
  end
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    {rst_n, text400_mode, slow_reference_clock, refresh_div_en, mem_activity} = '0;
    {crt_only, io_activity, misc_clk_sel} = 4'hf;
    {crt_index, video_data_pins_in, volt_detect} = {8'h00, 8'h5a, 5'h15};
    pins_int = '1;
    repeat (3) @(posedge clk);
    #1 rst_n = 1'b1;
    t_basic;
    t_lock;
    t_feat;
    t_clock;
    t_volt;
    t_status;
    t_refresh;
    conclude;
  end
endmodule : tb_top
